// File: common/sgm_pkg.sv
// shared constants and types for the signal modulator
package sgm_pkg;

  // register byte addresses
  localparam logic [7:0] SGM_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SGM_ADDR_SRC = 8'h04;
  localparam logic [7:0] SGM_ADDR_CARRIER_HIGH_SIGNAL = 8'h08;
  localparam logic [7:0] SGM_ADDR_CARRIER_LOW_SIGNAL = 8'h0C;
  localparam int SGM_ADDR_W = 8;

  // control register field positions
  localparam int SGM_CTRL_EN_BIT = 7;
  localparam int SGM_CTRL_OINV_BIT = 4;
  localparam int SGM_CTRL_OUT_BIT = 3;
  localparam int SGM_CTRL_SWBIT_BIT = 0;

  // carrier register field positions
  localparam int SGM_CAR_INV_BIT = 6;
  localparam int SGM_CAR_SYNC_BIT = 5;
  localparam int SGM_SEL_W = 4;

  // reset values
  localparam logic [SGM_SEL_W-1:0] SGM_SEL_RESET = 4'h0;

  // modulating source codes
  localparam logic [3:0] SGM_MS_SWBIT = 4'h0;
  localparam logic [3:0] SGM_MS_EXTPIN = 4'h1;
  localparam logic [3:0] SGM_MS_CAPTURE_COMPARE_ONE = 4'h2;
  localparam logic [3:0] SGM_MS_CAPTURE_COMPARE_TWO = 4'h3;
  localparam logic [3:0] SGM_MS_PULSE_WIDTH_FIVE = 4'h4;
  localparam logic [3:0] SGM_MS_PULSE_WIDTH_SIX = 4'h5;
  localparam logic [3:0] SGM_MS_CMP1 = 4'h6;
  localparam logic [3:0] SGM_MS_CMP2 = 4'h7;
  localparam logic [3:0] SGM_MS_SDO = 4'h8;
  localparam logic [3:0] SGM_MS_RSVD = 4'h9;
  localparam logic [3:0] SGM_MS_TX = 4'hA;
  localparam logic [3:0] SGM_MS_NCO = 4'hB;
  localparam logic [3:0] SGM_MS_LOGIC_CELL_ONE = 4'hC;
  localparam logic [3:0] SGM_MS_LOGIC_CELL_TWO = 4'hD;
  localparam logic [3:0] SGM_MS_LOGIC_CELL_THREE = 4'hE;
  localparam logic [3:0] SGM_MS_LOGIC_CELL_FOUR = 4'hF;

  // carrier source codes
  localparam logic [3:0] SGM_CS_GND = 4'h0;
  localparam logic [3:0] SGM_CS_SYSCLK = 4'h1;
  localparam logic [3:0] SGM_CS_HFOSC = 4'h2;
  localparam logic [3:0] SGM_CS_REFCLK = 4'h3;
  localparam logic [3:0] SGM_CS_PIN1 = 4'h4;
  localparam logic [3:0] SGM_CS_PIN2 = 4'h5;
  localparam logic [3:0] SGM_CS_CAPTURE_COMPARE_ONE = 4'h6;
  localparam logic [3:0] SGM_CS_CAPTURE_COMPARE_TWO = 4'h7;
  localparam logic [3:0] SGM_CS_PULSE_WIDTH_FIVE = 4'h8;
  localparam logic [3:0] SGM_CS_PULSE_WIDTH_SIX = 4'h9;
  localparam logic [3:0] SGM_CS_NCO = 4'hA;
  localparam logic [3:0] SGM_CS_LOGIC_CELL_ONE = 4'hB;
  localparam logic [3:0] SGM_CS_LOGIC_CELL_TWO = 4'hC;
  localparam logic [3:0] SGM_CS_LOGIC_CELL_THREE = 4'hD;
  localparam logic [3:0] SGM_CS_LOGIC_CELL_FOUR = 4'hE;
  localparam logic [3:0] SGM_CS_RSVD = 4'hF;

  // on-chip peripheral outputs, all on clk_sys
  typedef struct packed {
    logic capture_compare_one;
    logic capture_compare_two;
    logic pulse_width_five;
    logic pulse_width_six;
    logic serial_data_out;
    logic comparator_one;
    logic comparator_two;
    logic async_serial_transmitter;
    logic numeric_oscillator_output;
    logic logic_cell_one;
    logic logic_cell_two;
    logic logic_cell_three;
    logic logic_cell_four;
  } sgm_periph_type;

  // one carrier configuration register
  typedef struct packed {
    logic invert;
    logic sync_enable;
    logic [SGM_SEL_W-1:0] select;
  } sgm_carrier_cfg_type;

endpackage : sgm_pkg

// File: verilog/sgm_pin_sync.sv
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module sgm_pin_sync
  import sgm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // pin and synchronised level
  input wire logic pin_in,
  output logic level_q
);

  logic [2:0] stage_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stage_q <= 3'h0;
    end else begin
      stage_q <= {stage_q[1:0], pin_in};
    end
  end

  // a change counts once the second and third stages agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      level_q <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      level_q <= stage_q[2];
    end
  end

endmodule : sgm_pin_sync

// File: verilog/sgm_modulator.sv
// signal modulator: source selection, carrier sync, mixer and apb registers
// Functional notes
// - output is the active carrier gated by the modulating signal, driven to the pin
// - modulating signal high selects the carrier high signal
// - modulating signal low selects the carrier low signal
// - the modulator runs only while software sets modulator_enable
// - with enable clear both carriers are forced to ground
// - with enable clear the software bit is the modulating signal
// - clearing enable leaves stored source selections untouched
// - setting enable again restores the programmed selections
// - while disabled the output pin is held low
// - modulating source picked by a 4-bit field among fifteen sources
// - carrier high picked by a 4-bit field among fifteen carrier sources
// - carrier low has its own 4-bit field over the same sources
// - serial data out is a valid source only in spi mode
// - code 0 software bit, 1 external pin, 11 oscillator, 9 reserved
// - synced carrier stays until, or waits for, its next falling edge
// - each carrier source may be inverted by its own polarity bit
// - output polarity bit inverts the output so it idles high
`timescale 1ns/1ps
module sgm_modulator
  import sgm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [SGM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // on-chip sources
  input wire sgm_periph_type periph,
  input wire logic spi_mode,
  // asynchronous clock and pin sources
  input wire logic internal_high_freq_oscillator,
  input wire logic reference_clock,
  input wire logic external_modulator_pin,
  input wire logic external_carrier_pin_one,
  input wire logic external_carrier_pin_two,
  // modulated output pin
  output logic modulated_output
);

  logic enable_q;
  logic output_invert_q;
  logic software_modulation_bit_q;
  logic [SGM_SEL_W-1:0] modulating_source_select_q;
  sgm_carrier_cfg_type carrier_high_signal_cfg_q;
  sgm_carrier_cfg_type carrier_low_signal_cfg_q;
  logic out_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic sysclk_div_q;
  logic carrier_high_signal_prev_q;
  logic carrier_low_signal_prev_q;
  logic hact_q;
  logic lact_q;
  logic hfosc_s;
  logic refclk_s;
  logic modpin_s;
  logic cpin1_s;
  logic cpin2_s;
  logic [SGM_SEL_W-1:0] mod_sel;
  logic modulating_signal;
  logic carrier_high_signal;
  logic carrier_low_signal;
  logic hact;
  logic lact;
  logic mix;
  logic wr_en;
  logic setup;

  sgm_pin_sync u_sync_hfosc (
    .clk_sys(clk_sys),
    .srst(srst),
    .pin_in(internal_high_freq_oscillator),
    .level_q(hfosc_s)
  );
  sgm_pin_sync u_sync_refclk (
    .clk_sys(clk_sys),
    .srst(srst),
    .pin_in(reference_clock),
    .level_q(refclk_s)
  );
  sgm_pin_sync u_sync_modpin (
    .clk_sys(clk_sys),
    .srst(srst),
    .pin_in(external_modulator_pin),
    .level_q(modpin_s)
  );
  sgm_pin_sync u_sync_cpin1 (
    .clk_sys(clk_sys),
    .srst(srst),
    .pin_in(external_carrier_pin_one),
    .level_q(cpin1_s)
  );
  sgm_pin_sync u_sync_cpin2 (
    .clk_sys(clk_sys),
    .srst(srst),
    .pin_in(external_carrier_pin_two),
    .level_q(cpin2_s)
  );

  // carrier source mux shared by both carriers, reserved is low
  function automatic logic carrier_pick(input logic [SGM_SEL_W-1:0] sel,
                                        input logic sysclk, input logic hf,
                                        input logic rc, input logic p1,
                                        input logic p2, input sgm_periph_type pr);
    logic v;
    v = 1'b0;
    unique case (sel)
      SGM_CS_GND: v = 1'b0;
      SGM_CS_SYSCLK: v = sysclk;
      SGM_CS_HFOSC: v = hf;
      SGM_CS_REFCLK: v = rc;
      SGM_CS_PIN1: v = p1;
      SGM_CS_PIN2: v = p2;
      SGM_CS_CAPTURE_COMPARE_ONE: v = pr.capture_compare_one;
      SGM_CS_CAPTURE_COMPARE_TWO: v = pr.capture_compare_two;
      SGM_CS_PULSE_WIDTH_FIVE: v = pr.pulse_width_five;
      SGM_CS_PULSE_WIDTH_SIX: v = pr.pulse_width_six;
      SGM_CS_NCO: v = pr.numeric_oscillator_output;
      SGM_CS_LOGIC_CELL_ONE: v = pr.logic_cell_one;
      SGM_CS_LOGIC_CELL_TWO: v = pr.logic_cell_two;
      SGM_CS_LOGIC_CELL_THREE: v = pr.logic_cell_three;
      SGM_CS_LOGIC_CELL_FOUR: v = pr.logic_cell_four;
      SGM_CS_RSVD: v = 1'b0;
    endcase
    return v;
  endfunction : carrier_pick

  // system clock as a carrier is approximated by a half-rate toggle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sysclk_div_q <= 1'b0;
    end else begin
      sysclk_div_q <= ~sysclk_div_q;
    end
  end

  // software bit replaces the programmed source while disabled
  assign mod_sel = enable_q ? modulating_source_select_q : SGM_MS_SWBIT;

  // modulating source mux, code map, spi gate, reserved
  always_comb begin
    modulating_signal = 1'b0;
    unique case (mod_sel)
      SGM_MS_SWBIT: modulating_signal = software_modulation_bit_q;
      SGM_MS_EXTPIN: modulating_signal = modpin_s;
      SGM_MS_CAPTURE_COMPARE_ONE: modulating_signal = periph.capture_compare_one;
      SGM_MS_CAPTURE_COMPARE_TWO: modulating_signal = periph.capture_compare_two;
      SGM_MS_PULSE_WIDTH_FIVE: modulating_signal = periph.pulse_width_five;
      SGM_MS_PULSE_WIDTH_SIX: modulating_signal = periph.pulse_width_six;
      SGM_MS_CMP1: modulating_signal = periph.comparator_one;
      SGM_MS_CMP2: modulating_signal = periph.comparator_two;
      SGM_MS_SDO: modulating_signal = periph.serial_data_out & spi_mode;
      SGM_MS_RSVD: modulating_signal = 1'b0;
      SGM_MS_TX: modulating_signal = periph.async_serial_transmitter;
      SGM_MS_NCO: modulating_signal = periph.numeric_oscillator_output;
      SGM_MS_LOGIC_CELL_ONE: modulating_signal = periph.logic_cell_one;
      SGM_MS_LOGIC_CELL_TWO: modulating_signal = periph.logic_cell_two;
      SGM_MS_LOGIC_CELL_THREE: modulating_signal = periph.logic_cell_three;
      SGM_MS_LOGIC_CELL_FOUR: modulating_signal = periph.logic_cell_four;
    endcase
  end

  // carriers grounded while disabled, selections come back on enable
  // carrier low uses its own field, per-carrier inversion
  always_comb begin
    carrier_high_signal = 1'b0;
    carrier_low_signal = 1'b0;
    if (enable_q) begin
      carrier_high_signal = carrier_high_signal_cfg_q.invert ^ carrier_pick(carrier_high_signal_cfg_q.select,
        sysclk_div_q, hfosc_s, refclk_s, cpin1_s, cpin2_s, periph);
      carrier_low_signal = carrier_low_signal_cfg_q.invert ^ carrier_pick(carrier_low_signal_cfg_q.select,
        sysclk_div_q, hfosc_s, refclk_s, cpin1_s, cpin2_s, periph);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      carrier_high_signal_prev_q <= 1'b0;
      carrier_low_signal_prev_q <= 1'b0;
    end else begin
      carrier_high_signal_prev_q <= carrier_high_signal;
      carrier_low_signal_prev_q <= carrier_low_signal;
    end
  end

  // synced carrier changes activity only on its own falling edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hact_q <= 1'b0;
    end else if (!carrier_high_signal_cfg_q.sync_enable || (carrier_high_signal_prev_q && !carrier_high_signal)) begin
      hact_q <= modulating_signal;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lact_q <= 1'b1;
    end else if (!carrier_low_signal_cfg_q.sync_enable || (carrier_low_signal_prev_q && !carrier_low_signal)) begin
      lact_q <= ~modulating_signal;
    end
  end

  // high carrier active with modulating high, low carrier with it low
  assign hact = carrier_high_signal_cfg_q.sync_enable ? hact_q : modulating_signal;
  assign lact = carrier_low_signal_cfg_q.sync_enable ? lact_q : ~modulating_signal;
  assign mix = (hact & carrier_high_signal) | (lact & carrier_low_signal);

  // mixed signal to pin, low while disabled, output inversion
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out_q <= 1'b0;
    end else begin
      out_q <= enable_q ? (mix ^ output_invert_q) : 1'b0;
    end
  end

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_q && pwrite;

  // enable and selections change only by register writes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      enable_q <= 1'b0;
      output_invert_q <= 1'b0;
      software_modulation_bit_q <= 1'b0;
      modulating_source_select_q <= SGM_SEL_RESET;
      carrier_high_signal_cfg_q <= '0;
      carrier_low_signal_cfg_q <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        SGM_ADDR_CTRL: begin
          enable_q <= pwdata[SGM_CTRL_EN_BIT];
          output_invert_q <= pwdata[SGM_CTRL_OINV_BIT];
          software_modulation_bit_q <= pwdata[SGM_CTRL_SWBIT_BIT];
        end
        SGM_ADDR_SRC: modulating_source_select_q <= pwdata[SGM_SEL_W-1:0];
        SGM_ADDR_CARRIER_HIGH_SIGNAL: begin
          carrier_high_signal_cfg_q <= {pwdata[SGM_CAR_INV_BIT], pwdata[SGM_CAR_SYNC_BIT],
                         pwdata[SGM_SEL_W-1:0]};
        end
        SGM_ADDR_CARRIER_LOW_SIGNAL: begin
          carrier_low_signal_cfg_q <= {pwdata[SGM_CAR_INV_BIT], pwdata[SGM_CAR_SYNC_BIT],
                         pwdata[SGM_SEL_W-1:0]};
        end
        default: ;
      endcase
    end
  end

  // apb answer: zero wait states, read data latched in the setup cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= 1'b0;
      if (setup) begin
        prdata_q <= 32'h0000_0000;
        unique case (paddr)
          SGM_ADDR_CTRL: begin
            prdata_q[SGM_CTRL_EN_BIT] <= enable_q;
            prdata_q[SGM_CTRL_OINV_BIT] <= output_invert_q;
            prdata_q[SGM_CTRL_OUT_BIT] <= out_q;
            prdata_q[SGM_CTRL_SWBIT_BIT] <= software_modulation_bit_q;
          end
          SGM_ADDR_SRC: prdata_q[SGM_SEL_W-1:0] <= modulating_source_select_q;
          SGM_ADDR_CARRIER_HIGH_SIGNAL: begin
            prdata_q[SGM_CAR_INV_BIT] <= carrier_high_signal_cfg_q.invert;
            prdata_q[SGM_CAR_SYNC_BIT] <= carrier_high_signal_cfg_q.sync_enable;
            prdata_q[SGM_SEL_W-1:0] <= carrier_high_signal_cfg_q.select;
          end
          SGM_ADDR_CARRIER_LOW_SIGNAL: begin
            prdata_q[SGM_CAR_INV_BIT] <= carrier_low_signal_cfg_q.invert;
            prdata_q[SGM_CAR_SYNC_BIT] <= carrier_low_signal_cfg_q.sync_enable;
            prdata_q[SGM_SEL_W-1:0] <= carrier_low_signal_cfg_q.select;
          end
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign modulated_output = out_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  out_follows_mix_a: assert property (enable_q |=> out_q == $past(mix ^ output_invert_q))
    else $error("output does not follow mixed signal");
  high_carrier_used_a: assert property (enable_q && !carrier_high_signal_cfg_q.sync_enable && modulating_signal
    && !carrier_low_signal_cfg_q.sync_enable |=> out_q == $past(carrier_high_signal ^ output_invert_q))
    else $error("carrier high not used while modulating high");
  low_carrier_used_a: assert property (enable_q && !carrier_low_signal_cfg_q.sync_enable && !modulating_signal
    && !carrier_high_signal_cfg_q.sync_enable |=> out_q == $past(carrier_low_signal ^ output_invert_q))
    else $error("carrier low not used while modulating low");
  enable_write_a: assert property (wr_en && paddr == SGM_ADDR_CTRL
    |=> enable_q == $past(pwdata[SGM_CTRL_EN_BIT]))
    else $error("enable bit not taken from write");
  carriers_grounded_a: assert property (!enable_q
    |-> !carrier_high_signal && !carrier_low_signal)
    else $error("carrier not grounded while disabled");
  soft_bit_routed_a: assert property (!enable_q
    |-> modulating_signal == software_modulation_bit_q)
    else $error("software bit not routed while disabled");
  selects_retained_a: assert property (!enable_q && !wr_en
    |=> $stable(modulating_source_select_q) && $stable(carrier_high_signal_cfg_q) && $stable(carrier_low_signal_cfg_q))
    else $error("selection changed while disabled");
  selects_restored_a: assert property (enable_q |-> mod_sel == modulating_source_select_q)
    else $error("programmed source not restored");
  out_low_disabled_a: assert property (!enable_q |=> !out_q)
    else $error("output not low while disabled");
  sdo_spi_gate_a: assert property (enable_q && mod_sel == SGM_MS_SDO && !spi_mode
    |-> !modulating_signal)
    else $error("serial data passed outside spi mode");
  reserved_low_a: assert property (enable_q && mod_sel == SGM_MS_RSVD |-> !modulating_signal)
    else $error("reserved source not low");
  sync_hold_a: assert property (carrier_high_signal_cfg_q.sync_enable && hact_q && !modulating_signal
    && !(carrier_high_signal_prev_q && !carrier_high_signal) |=> hact_q)
    else $error("synced carrier high dropped before falling edge");
  idle_high_a: assert property (enable_q && output_invert_q && !mix |=> out_q)
    else $error("inverted output does not idle high");

  cover_enable_c: cover property (!enable_q ##1 enable_q ##[1:20] out_q);
  cover_sync_c: cover property (carrier_high_signal_cfg_q.sync_enable && $fell(modulating_signal) ##[1:20] !hact_q);
  cover_read_c: cover property (psel && penable && pready_q && !pwrite);
  cover_inv_c: cover property (enable_q && output_invert_q ##1 out_q);

endmodule : sgm_modulator

// File: tb/sgm_source_model.sv
// behavioural model of the peripheral outputs, free clocks and pins
`timescale 1ns/1ps
module sgm_source_model
  import sgm_pkg::*;
(
  // clock and requested levels
  input wire logic clk_sys,
  input wire sgm_periph_type periph_set,
  input wire logic [2:0] pin_set,
  // sources seen by the modulator
  output sgm_periph_type periph,
  output logic hf_osc,
  output logic ref_clk,
  output logic [2:0] pins
);
  // peripherals live on clk_sys and change on its edge
  always_ff @(posedge clk_sys) begin
    periph <= periph_set;
  end
  // pins move a little after the edge, unrelated to clk_sys; they start low
  // so that an unchanged request never leaves them unknown
  initial begin
    pins = 3'b000;
    forever begin
      @(pin_set);
      pins <= #3 pin_set;
    end
  end
  // oscillators run free at their own rates
  initial begin
    hf_osc = 1'b0;
    forever #7 hf_osc = ~hf_osc;
  end
  initial begin
    ref_clk = 1'b0;
    forever #13 ref_clk = ~ref_clk;
  end
endmodule : sgm_source_model

// File: tb/data_signal_modulator_test.sv
// self-checking bench for the signal modulator
`timescale 1ns/1ps
module data_signal_modulator_test
  import sgm_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [SGM_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic spi_mode = 1'b0;
  logic modulated_output;
  sgm_periph_type pset = '0;
  sgm_periph_type periph;
  logic [2:0] pins_set = '0;
  logic [2:0] pins;
  logic hf_osc;
  logic ref_clk;
  int mismatches = 0;
  int n_tests = 0;
  logic [7:0] ctrl_w, src_w, carrier_high_signal_w, carrier_low_signal_w;
  logic [31:0] rd;
  logic err;
  logic ex;

  sgm_modulator dut (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph(periph), .spi_mode(spi_mode),
    .internal_high_freq_oscillator(hf_osc), .reference_clock(ref_clk),
    .external_modulator_pin(pins[0]), .external_carrier_pin_one(pins[1]),
    .external_carrier_pin_two(pins[2]), .modulated_output(modulated_output));

  sgm_source_model model (.clk_sys(clk_sys), .periph_set(pset), .pin_set(pins_set),
    .periph(periph), .hf_osc(hf_osc), .ref_clk(ref_clk), .pins(pins));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t bit got %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t word got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : settle

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h000000, d}, r, e);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    check_word(r, {24'h000000, exp});
  endtask : rd_chk

  function automatic logic car_val(input logic [3:0] c);
    case (c)
      SGM_CS_PIN1: return pins_set[1];
      SGM_CS_PIN2: return pins_set[2];
      SGM_CS_CAPTURE_COMPARE_ONE: return pset.capture_compare_one;
      SGM_CS_CAPTURE_COMPARE_TWO: return pset.capture_compare_two;
      SGM_CS_PULSE_WIDTH_FIVE: return pset.pulse_width_five;
      SGM_CS_PULSE_WIDTH_SIX: return pset.pulse_width_six;
      SGM_CS_NCO: return pset.numeric_oscillator_output;
      SGM_CS_LOGIC_CELL_ONE: return pset.logic_cell_one;
      SGM_CS_LOGIC_CELL_TWO: return pset.logic_cell_two;
      SGM_CS_LOGIC_CELL_THREE: return pset.logic_cell_three;
      SGM_CS_LOGIC_CELL_FOUR: return pset.logic_cell_four;
      default: return 1'b0;
    endcase
  endfunction : car_val

  function automatic logic mod_val(input logic [3:0] c);
    case (c)
      SGM_MS_SWBIT: return ctrl_w[SGM_CTRL_SWBIT_BIT];
      SGM_MS_EXTPIN: return pins_set[0];
      SGM_MS_CAPTURE_COMPARE_ONE: return pset.capture_compare_one;
      SGM_MS_CAPTURE_COMPARE_TWO: return pset.capture_compare_two;
      SGM_MS_PULSE_WIDTH_FIVE: return pset.pulse_width_five;
      SGM_MS_PULSE_WIDTH_SIX: return pset.pulse_width_six;
      SGM_MS_CMP1: return pset.comparator_one;
      SGM_MS_CMP2: return pset.comparator_two;
      SGM_MS_SDO: return pset.serial_data_out & spi_mode;
      SGM_MS_TX: return pset.async_serial_transmitter;
      SGM_MS_NCO: return pset.numeric_oscillator_output;
      SGM_MS_LOGIC_CELL_ONE: return pset.logic_cell_one;
      SGM_MS_LOGIC_CELL_TWO: return pset.logic_cell_two;
      SGM_MS_LOGIC_CELL_THREE: return pset.logic_cell_three;
      SGM_MS_LOGIC_CELL_FOUR: return pset.logic_cell_four;
      default: return 1'b0;
    endcase
  endfunction : mod_val

  // expected pin level for the current configuration
  function automatic logic exp_out();
    logic hc, lc;
    if (!ctrl_w[SGM_CTRL_EN_BIT]) return 1'b0;
    hc = car_val(carrier_high_signal_w[3:0]) ^ carrier_high_signal_w[SGM_CAR_INV_BIT];
    lc = car_val(carrier_low_signal_w[3:0]) ^ carrier_low_signal_w[SGM_CAR_INV_BIT];
    return (mod_val(src_w[3:0]) ? hc : lc) ^ ctrl_w[SGM_CTRL_OINV_BIT];
  endfunction : exp_out

  // static carrier: clocked source codes 1 to 3 are moved to codes 4 to 6
  function automatic logic [7:0] pick_car();
    logic [3:0] c;
    logic inv;
    c = 4'($urandom_range(15));
    if (c >= 4'h1 && c <= 4'h3) c = c + 4'h3;
    inv = (c != SGM_CS_GND && c != SGM_CS_RSVD) ? 1'($urandom) : 1'b0;
    return {1'b0, inv, 2'b00, c};
  endfunction : pick_car

  initial begin
    settle(20000);
    mismatches++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h4c671c0d));
    settle(5);
    srst <= 1'b0;
    rd_chk(SGM_ADDR_CTRL, 8'h00);
    rd_chk(SGM_ADDR_SRC, 8'h00);
    rd_chk(SGM_ADDR_CARRIER_HIGH_SIGNAL, 8'h00);
    rd_chk(SGM_ADDR_CARRIER_LOW_SIGNAL, 8'h00);
    apb(1'b1, 8'h10, 32'h000000FF, rd, err);
    check_bit(err, 1'b1);
    apb(1'b0, 8'h10, 32'h00000000, rd, err);
    check_bit(err, 1'b1);
    check_word(rd, 32'h00000000);
    for (int i = 0; i < 48; i++) begin
      pset <= sgm_periph_type'(13'($urandom));
      pins_set <= 3'($urandom);
      spi_mode <= 1'($urandom);
      src_w = {4'h0, 4'($urandom_range(15))};
      carrier_high_signal_w = pick_car();
      carrier_low_signal_w = pick_car();
      ctrl_w = {($urandom_range(3) != 0), 2'b00, 1'($urandom), 3'b000, 1'($urandom)};
      wr(SGM_ADDR_SRC, src_w);
      wr(SGM_ADDR_CARRIER_HIGH_SIGNAL, carrier_high_signal_w);
      wr(SGM_ADDR_CARRIER_LOW_SIGNAL, carrier_low_signal_w);
      wr(SGM_ADDR_CTRL, ctrl_w);
      settle(12);
      ex = exp_out();
      check_bit(modulated_output, ex);
      rd_chk(SGM_ADDR_CTRL, (ctrl_w & 8'h91) | {4'h0, ex, 3'b000});
      wr(SGM_ADDR_CTRL, ctrl_w & 8'h7F);
      settle(4);
      check_bit(modulated_output, 1'b0);
      rd_chk(SGM_ADDR_SRC, src_w);
      rd_chk(SGM_ADDR_CARRIER_HIGH_SIGNAL, carrier_high_signal_w);
      rd_chk(SGM_ADDR_CARRIER_LOW_SIGNAL, carrier_low_signal_w);
      wr(SGM_ADDR_CTRL, ctrl_w);
      settle(6);
      check_bit(modulated_output, ex);
    end
    // carrier high synchronised to a pulse-width output
    pset <= '0;
    wr(SGM_ADDR_SRC, 8'h00);
    wr(SGM_ADDR_CARRIER_LOW_SIGNAL, 8'h00);
    wr(SGM_ADDR_CARRIER_HIGH_SIGNAL, 8'h20 | {4'h0, SGM_CS_PULSE_WIDTH_FIVE});
    wr(SGM_ADDR_CTRL, 8'h80);
    pset.pulse_width_five <= 1'b1;
    settle(4);
    wr(SGM_ADDR_CTRL, 8'h81);
    settle(6);
    check_bit(modulated_output, 1'b0);
    pset.pulse_width_five <= 1'b0;
    settle(4);
    pset.pulse_width_five <= 1'b1;
    settle(6);
    check_bit(modulated_output, 1'b1);
    wr(SGM_ADDR_CTRL, 8'h80);
    settle(6);
    check_bit(modulated_output, 1'b1);
    pset.pulse_width_five <= 1'b0;
    settle(4);
    pset.pulse_width_five <= 1'b1;
    settle(6);
    check_bit(modulated_output, 1'b0);
    // carrier low synchronised to the other pulse-width output
    pset <= '0;
    wr(SGM_ADDR_CARRIER_HIGH_SIGNAL, 8'h00);
    wr(SGM_ADDR_CARRIER_LOW_SIGNAL, 8'h20 | {4'h0, SGM_CS_PULSE_WIDTH_SIX});
    pset.pulse_width_six <= 1'b1;
    settle(6);
    check_bit(modulated_output, 1'b1);
    wr(SGM_ADDR_CTRL, 8'h81);
    settle(6);
    check_bit(modulated_output, 1'b1);
    pset.pulse_width_six <= 1'b0;
    settle(4);
    pset.pulse_width_six <= 1'b1;
    settle(6);
    check_bit(modulated_output, 1'b0);
    wr(SGM_ADDR_CTRL, 8'h80);
    settle(6);
    check_bit(modulated_output, 1'b0);
    report_and_stop();
  end
endmodule : data_signal_modulator_test
